// ==== pcs_regs.sv ====
/*
  pci command/status low-half register bank with event capture, system-error request,
  strap-loaded bus master default and a masked interrupt.
  assumes bus-engine events arrive on clk_sys; strap pins are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none

module pcs_regs
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // strap pins
  input wire logic pci_boot_strap,
  input wire logic host_mode_strap,
  // bus engine side
  input wire pcs_evt_t evt,
  output pcs_ctl_t ctl,
  output logic serr_assert,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pcs_state_t s_ff;
  pcs_state_t nxt_s;
  logic set_ipe;
  logic serr_ev;
  logic cmd_wr;
  logic [31:0] cmd_word;

  // ------------------------------------------------------------
  // readback word
  // ------------------------------------------------------------
  always_comb
  begin
    cmd_word = '0;
    cmd_word[PCS_B_IPE] = s_ff.cmd.ipe;
    cmd_word[PCS_B_B2B_CAP] = PCS_FIX_B2B_CAP;
    cmd_word[PCS_B_HS_CAP] = PCS_FIX_HS_CAP;
    cmd_word[PCS_B_CAPL] = PCS_FIX_CAPL;
    cmd_word[PCS_B_B2B_EN] = s_ff.cmd.b2b;
    cmd_word[PCS_B_SER_EN] = s_ff.cmd.ser;
    cmd_word[PCS_B_STEP] = PCS_FIX_STEP;
    cmd_word[PCS_B_PER_EN] = s_ff.cmd.per;
    cmd_word[PCS_B_PAL] = PCS_FIX_PAL;
    cmd_word[PCS_B_MWI_EN] = s_ff.cmd.mwi;
    cmd_word[PCS_B_SCA] = PCS_FIX_SCA;
    cmd_word[PCS_B_BM_EN] = s_ff.cmd.bm;
    cmd_word[PCS_B_MEM_EN] = s_ff.cmd.mem;
    cmd_word[PCS_B_IO_EN] = s_ff.cmd.io;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.rdata = '0;
    cmd_wr = reg_wr && (reg_addr == PCS_OFF_CMD);
    // only errors seen as initiator, and only with response on
    set_ipe = evt.perr_seen && evt.initiator && s_ff.cmd.per;
    serr_ev = (evt.addr_perr || evt.sc_data_perr) && s_ff.cmd.ser && s_ff.cmd.per;
    nxt_s.serr = serr_ev;
    // first sync flop feeds the second only
    nxt_s.sync1 = {pci_boot_strap, host_mode_strap};
    nxt_s.sync2 = s_ff.sync1;
    if (s_ff.strap_cnt != PCS_STRAP_END)
    begin
      nxt_s.strap_cnt = s_ff.strap_cnt + 2'h1;
    end
    // straps caught once, after the synchroniser has filled
    if (s_ff.strap_cnt == PCS_STRAP_AT)
    begin
      nxt_s.cmd.bm = &s_ff.sync2;
    end
    if (cmd_wr)
    begin
      nxt_s.cmd.b2b = reg_wdata[PCS_B_B2B_EN];
      nxt_s.cmd.ser = reg_wdata[PCS_B_SER_EN];
      nxt_s.cmd.per = reg_wdata[PCS_B_PER_EN];
      nxt_s.cmd.mwi = reg_wdata[PCS_B_MWI_EN];
      nxt_s.cmd.bm = reg_wdata[PCS_B_BM_EN];
      nxt_s.cmd.mem = reg_wdata[PCS_B_MEM_EN];
      nxt_s.cmd.io = reg_wdata[PCS_B_IO_EN];
      if (reg_wdata[PCS_B_IPE])
      begin
        nxt_s.cmd.ipe = 1'h0;
      end
    end
    if (reg_wr && (reg_addr == PCS_OFF_ISTAT))
    begin
      nxt_s.istat = s_ff.istat & ~reg_wdata[PCS_EV_W-1:0];
    end
    if (reg_wr && (reg_addr == PCS_OFF_IMASK))
    begin
      nxt_s.imask = reg_wdata[PCS_EV_W-1:0];
    end
    // set after clear so a coincident event is never lost
    if (set_ipe)
    begin
      nxt_s.cmd.ipe = 1'h1;
    end
    nxt_s.istat[PCS_EV_IPE] = nxt_s.istat[PCS_EV_IPE] | set_ipe;
    nxt_s.istat[PCS_EV_SERR] = nxt_s.istat[PCS_EV_SERR] | serr_ev;
    if (reg_rd)
    begin
      unique case (reg_addr)
        PCS_OFF_CMD: nxt_s.rdata = cmd_word;
        PCS_OFF_ISTAT: nxt_s.rdata = {{(32-PCS_EV_W){1'h0}}, s_ff.istat};
        PCS_OFF_IMASK: nxt_s.rdata = {{(32-PCS_EV_W){1'h0}}, s_ff.imask};
        default: nxt_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s_ff <= '{sync1: 2'h0, sync2: 2'h0, strap_cnt: 2'h0,
               cmd: '{PCS_RST_FLAG, PCS_RST_EN, PCS_RST_EN, PCS_RST_EN,
                      PCS_RST_EN, PCS_RST_EN, PCS_RST_EN, PCS_RST_EN},
               istat: '0, imask: '0, serr: 1'h0, rdata: 32'h0};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // the bus engine must qualify every initiator and target action with these
  assign ctl.back_to_back_issue_enable = s_ff.cmd.b2b;
  assign ctl.parity_error_response_enable = s_ff.cmd.per;
  assign ctl.write_invalidate_enable = s_ff.cmd.mwi;
  assign ctl.bus_master_enable = s_ff.cmd.bm;
  assign ctl.memory_space_enable = s_ff.cmd.mem;
  assign ctl.io_space_enable = s_ff.cmd.io;
  assign ctl.special_cycle_accept = PCS_FIX_SCA;
  assign serr_assert = s_ff.serr;
  assign reg_rdata = s_ff.rdata;
  assign irq = |(s_ff.istat & s_ff.imask);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_cmd_rd;
    reg_rd && (reg_addr == PCS_OFF_CMD);
  endsequence

  sequence s_cmd_wr;
    reg_wr && (reg_addr == PCS_OFF_CMD);
  endsequence

  property p_ipe_set;
    evt.perr_seen && evt.initiator && ctl.parity_error_response_enable
      |=> s_ff.cmd.ipe && s_ff.istat[PCS_EV_IPE];
  endproperty
  a_ipe_set: assert property (p_ipe_set) else $error("parity flag not set");

  property p_ipe_cause;
    $rose(s_ff.cmd.ipe) |-> $past(evt.perr_seen && evt.initiator && s_ff.cmd.per);
  endproperty
  a_ipe_cause: assert property (p_ipe_cause) else $error("parity flag set without cause");

  property p_fixed_bits;
    s_cmd_rd |=> reg_rdata[PCS_B_B2B_CAP] && reg_rdata[PCS_B_HS_CAP] && reg_rdata[PCS_B_CAPL]
      && !reg_rdata[PCS_B_STEP] && !reg_rdata[PCS_B_PAL] && !reg_rdata[PCS_B_SCA];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bit wrong");

  property p_reserved;
    s_cmd_rd |=> reg_rdata[22] == 1'h0 && reg_rdata[19:10] == 10'h0 && reg_rdata[31:25] == 7'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit nonzero");

  property p_serr_cause;
    serr_assert |-> $past(s_ff.cmd.ser && s_ff.cmd.per && (evt.addr_perr || evt.sc_data_perr));
  endproperty
  a_serr_cause: assert property (p_serr_cause) else $error("system error without cause");

  property p_serr_fire;
    (evt.addr_perr || evt.sc_data_perr) && s_ff.cmd.ser && s_ff.cmd.per
      |=> serr_assert && s_ff.istat[PCS_EV_SERR];
  endproperty
  a_serr_fire: assert property (p_serr_fire) else $error("system error not raised");

  property p_enables_write;
    s_cmd_wr |=> ctl.back_to_back_issue_enable == $past(reg_wdata[PCS_B_B2B_EN])
      && ctl.write_invalidate_enable == $past(reg_wdata[PCS_B_MWI_EN])
      && ctl.parity_error_response_enable == $past(reg_wdata[PCS_B_PER_EN])
      && ctl.memory_space_enable == $past(reg_wdata[PCS_B_MEM_EN])
      && ctl.io_space_enable == $past(reg_wdata[PCS_B_IO_EN])
      && ctl.bus_master_enable == $past(reg_wdata[PCS_B_BM_EN]);
  endproperty
  a_enables_write: assert property (p_enables_write) else $error("enable not written");

  property p_no_parity_resp;
    !s_ff.cmd.per |=> !$rose(s_ff.cmd.ipe) && !serr_assert;
  endproperty
  a_no_parity_resp: assert property (p_no_parity_resp) else $error("parity response while off");

  property p_strap;
    s_ff.strap_cnt == PCS_STRAP_AT && !reg_wr |=> ctl.bus_master_enable == $past(&s_ff.sync2);
  endproperty
  a_strap: assert property (p_strap) else $error("bus master default wrong");

  property p_w1c;
    s_cmd_wr and reg_wdata[PCS_B_IPE] && !set_ipe |=> !s_ff.cmd.ipe;
  endproperty
  a_w1c: assert property (p_w1c) else $error("parity flag not cleared");

  property p_irq;
    s_ff.istat[PCS_EV_IPE] && s_ff.imask[PCS_EV_IPE] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  // ------------------------------------------------------------
  // assertions: flag and event capture
  // ------------------------------------------------------------
  sequence s_perr_as_master;
    evt.perr_seen && evt.initiator;
  endsequence

  sequence s_istat_rd;
    reg_rd && (reg_addr == PCS_OFF_ISTAT);
  endsequence

  sequence s_istat_wr;
    reg_wr && (reg_addr == PCS_OFF_ISTAT);
  endsequence

  sequence s_imask_wr;
    reg_wr && (reg_addr == PCS_OFF_IMASK);
  endsequence

  property p_ipe_read;
    s_cmd_rd |=> reg_rdata[PCS_B_IPE] == $past(s_ff.cmd.ipe);
  endproperty
  a_ipe_read: assert property (p_ipe_read) else $error("parity flag readback wrong");

  // sticky: only a write of one to the flag may take it down
  property p_ipe_hold;
    s_ff.cmd.ipe && !(reg_wr && (reg_addr == PCS_OFF_CMD) && reg_wdata[PCS_B_IPE]) |=> s_ff.cmd.ipe;
  endproperty
  a_ipe_hold: assert property (p_ipe_hold) else $error("parity flag lost");

  property p_no_target;
    !evt.initiator && !s_ff.cmd.ipe |=> !s_ff.cmd.ipe;
  endproperty
  a_no_target: assert property (p_no_target) else $error("parity flag set as target");

  property p_istat_read;
    s_istat_rd |=> reg_rdata == {{(32-PCS_EV_W){1'h0}}, $past(s_ff.istat)};
  endproperty
  a_istat_read: assert property (p_istat_read) else $error("event status readback wrong");

  property p_istat_w1c;
    s_istat_wr and !set_ipe && !serr_ev
      |=> (s_ff.istat & $past(reg_wdata[PCS_EV_W-1:0])) == {PCS_EV_W{1'h0}};
  endproperty
  a_istat_w1c: assert property (p_istat_w1c) else $error("event status not cleared");

  property p_imask_write;
    s_imask_wr |=> s_ff.imask == $past(reg_wdata[PCS_EV_W-1:0]);
  endproperty
  a_imask_write: assert property (p_imask_write) else $error("event mask not written");

  // an unmasked parity event must reach the interrupt one cycle later
  property p_irq_event;
    s_perr_as_master and ctl.parity_error_response_enable && s_ff.imask[PCS_EV_IPE] && !reg_wr |=> irq;
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("interrupt not raised by event");

  // ------------------------------------------------------------
  // assertions: system error request
  // ------------------------------------------------------------
  property p_serr_gate;
    !s_ff.cmd.ser |=> !serr_assert;
  endproperty
  a_serr_gate: assert property (p_serr_gate) else $error("system error while disabled");

  // a parity error on data alone is not a system error
  property p_serr_src;
    !evt.addr_perr && !evt.sc_data_perr |=> !serr_assert;
  endproperty
  a_serr_src: assert property (p_serr_src) else $error("system error from wrong source");

  // ------------------------------------------------------------
  // assertions: enables and straps
  // ------------------------------------------------------------
  property p_enables_read;
    s_cmd_rd |=> reg_rdata[PCS_B_B2B_EN] == $past(ctl.back_to_back_issue_enable)
      && reg_rdata[PCS_B_SER_EN] == $past(s_ff.cmd.ser)
      && reg_rdata[PCS_B_PER_EN] == $past(ctl.parity_error_response_enable)
      && reg_rdata[PCS_B_MWI_EN] == $past(ctl.write_invalidate_enable)
      && reg_rdata[PCS_B_BM_EN] == $past(ctl.bus_master_enable)
      && reg_rdata[PCS_B_MEM_EN] == $past(ctl.memory_space_enable)
      && reg_rdata[PCS_B_IO_EN] == $past(ctl.io_space_enable);
  endproperty
  a_enables_read: assert property (p_enables_read) else $error("enable readback wrong");

  // enables move only on a command write; the strap load touches bus master alone
  property p_enables_hold;
    !(reg_wr && (reg_addr == PCS_OFF_CMD)) |=> $stable(ctl.back_to_back_issue_enable)
      && $stable(ctl.parity_error_response_enable) && $stable(ctl.write_invalidate_enable)
      && $stable(ctl.memory_space_enable) && $stable(ctl.io_space_enable) && $stable(s_ff.cmd.ser);
  endproperty
  a_enables_hold: assert property (p_enables_hold) else $error("enable changed without write");

  property p_strap_hold;
    s_ff.strap_cnt == PCS_STRAP_END && !(reg_wr && (reg_addr == PCS_OFF_CMD))
      |=> $stable(ctl.bus_master_enable);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("bus master changed without write");

  property p_special_cycles;
    s_cmd_rd |=> !reg_rdata[PCS_B_SCA] && !ctl.special_cycle_accept;
  endproperty
  a_special_cycles: assert property (p_special_cycles) else $error("special cycles accepted");

  property p_caps_read;
    s_cmd_rd |=> reg_rdata[PCS_B_HS_CAP] && reg_rdata[PCS_B_CAPL]
      && !reg_rdata[PCS_B_STEP] && !reg_rdata[PCS_B_PAL];
  endproperty
  a_caps_read: assert property (p_caps_read) else $error("capability bit wrong");

  // ------------------------------------------------------------
  // assertions: register port
  // ------------------------------------------------------------
  // read data stand for one cycle only, so a stale word cannot be taken twice
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

  property p_rdata_unmapped;
    reg_rd && (reg_addr != PCS_OFF_CMD) && (reg_addr != PCS_OFF_ISTAT) && (reg_addr != PCS_OFF_IMASK)
      |=> reg_rdata == 32'h0;
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read not zero");

endmodule // pcs_regs

`default_nettype wire

// ==== pcs_pkg.sv ====
/*
  package for the pci command/status low-half register bank: offsets, field positions,
  fixed and reset values, event bit layout, and the state and carrier structs.
  assumes a single clock domain and a plain address/strobe register port.
*/
`default_nettype none

package pcs_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] PCS_OFF_CMD = 8'h00;
  localparam logic [7:0] PCS_OFF_ISTAT = 8'h04;
  localparam logic [7:0] PCS_OFF_IMASK = 8'h08;

  // ------------------------------------------------------------
  // field positions of pci_command_and_status
  // ------------------------------------------------------------
  localparam int PCS_B_IPE = 24;
  localparam int PCS_B_B2B_CAP = 23;
  localparam int PCS_B_HS_CAP = 21;
  localparam int PCS_B_CAPL = 20;
  localparam int PCS_B_B2B_EN = 9;
  localparam int PCS_B_SER_EN = 8;
  localparam int PCS_B_STEP = 7;
  localparam int PCS_B_PER_EN = 6;
  localparam int PCS_B_PAL = 5;
  localparam int PCS_B_MWI_EN = 4;
  localparam int PCS_B_SCA = 3;
  localparam int PCS_B_BM_EN = 2;
  localparam int PCS_B_MEM_EN = 1;
  localparam int PCS_B_IO_EN = 0;

  // ------------------------------------------------------------
  // fixed and reset values
  // ------------------------------------------------------------
  localparam logic PCS_FIX_B2B_CAP = 1'h1;
  localparam logic PCS_FIX_HS_CAP = 1'h1;
  localparam logic PCS_FIX_CAPL = 1'h1;
  localparam logic PCS_FIX_STEP = 1'h0;
  localparam logic PCS_FIX_PAL = 1'h0;
  localparam logic PCS_FIX_SCA = 1'h0;
  localparam logic PCS_RST_EN = 1'h0;
  localparam logic PCS_RST_FLAG = 1'h0;

  // ------------------------------------------------------------
  // interrupt events and strap timing
  // ------------------------------------------------------------
  localparam int PCS_EV_IPE = 0;
  localparam int PCS_EV_SERR = 1;
  localparam int PCS_EV_W = 2;
  localparam logic [1:0] PCS_STRAP_AT = 2'h2;
  localparam logic [1:0] PCS_STRAP_END = 2'h3;

  typedef struct packed {
    logic ipe;
    logic b2b;
    logic ser;
    logic per;
    logic mwi;
    logic bm;
    logic mem;
    logic io;
  } pcs_cmd_t;

  // events from the pci bus engine, same clock
  typedef struct packed {
    logic perr_seen;
    logic initiator;
    logic addr_perr;
    logic sc_data_perr;
  } pcs_evt_t;

  // enables handed to the pci bus engine
  typedef struct packed {
    logic back_to_back_issue_enable;
    logic parity_error_response_enable;
    logic write_invalidate_enable;
    logic bus_master_enable;
    logic memory_space_enable;
    logic io_space_enable;
    logic special_cycle_accept;
  } pcs_ctl_t;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] strap_cnt;
    pcs_cmd_t cmd;
    logic [PCS_EV_W-1:0] istat;
    logic [PCS_EV_W-1:0] imask;
    logic serr;
    logic [31:0] rdata;
  } pcs_state_t;

endpackage

`default_nettype wire

// ==== pcs_engine_model.sv ====
/*
  model of the pci bus engine that reports parity and special cycle events to pcs_regs.
  assumes the bench calls fire right after a rising edge of clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none

module pcs_engine_model
  import pcs_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // event report
  output var pcs_evt_t evt
);
  initial evt = '0;

  // ------------------------------------------------------------
  // one-cycle report, then quiet so no event is seen twice
  // ------------------------------------------------------------
  task automatic fire(input logic [3:0] pat);
    evt <= pcs_evt_t'(pat);
    @(posedge clk_sys);
    evt <= '0;
  endtask
endmodule // pcs_engine_model

`default_nettype wire

// ==== tb_pci_command_status_low.sv ====
/*
  self-checking bench for pcs_regs: register tasks, events through the engine model,
  read results checked from a queue by a watcher on the falling edge.
  assumes pcs_engine_model is compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_pci_command_status_low;
  import pcs_pkg::*;
  localparam logic [31:0] FIXED = 32'h00b00000;
  localparam logic [31:0] RW_MASK = 32'h00000357;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic boot_strap;
  logic host_strap;
  pcs_evt_t evt;
  pcs_ctl_t ctl;
  logic serr_assert;
  logic irq;
  logic [31:0] exp_q[$];
  logic rd_pend = 1'h0;
  int mismatches = 0;
  int comparisons = 0;
  integer seed = 32'h6c7b80f9;

  pcs_regs i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pci_boot_strap(boot_strap),
    .host_mode_strap(host_strap), .evt(evt), .ctl(ctl), .serr_assert(serr_assert), .irq(irq));
  pcs_engine_model i_eng (.clk_sys(clk_sys), .evt(evt));

  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // one strobe cycle; consecutive calls give back-to-back accesses
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    acc(1'h0, 1'h1, a, 32'h0);
  endtask

  task automatic idle;
    acc(1'h0, 1'h0, reg_addr, reg_wdata);
  endtask

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(negedge clk_sys)
  begin
    if (rd_pend)
      chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    rd_pend = reg_rd;
  end

  initial
  begin
    #(50 * 4000);
    mismatches++;
    $display("unexpected watchdog expiry");
    stop_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [3:0] pat;
    logic [1:0] m;
    logic per, ser, flag, serr;
    boot_strap <= 1'($random(seed));
    host_strap <= 1'($random(seed));
    repeat (16) @(posedge clk_sys);
    resetn <= 1'h1;
    repeat (4) @(posedge clk_sys);
    rd(PCS_OFF_CMD, FIXED | {29'h0, boot_strap & host_strap, 2'h0});
    rd(PCS_OFF_ISTAT, 32'h0);
    rd(PCS_OFF_IMASK, 32'h0);
    acc(1'h1, 1'h0, 8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      d = $random(seed);
      acc(1'h1, 1'h0, PCS_OFF_CMD, d);
      rd(PCS_OFF_CMD, FIXED | (d & RW_MASK));
      idle();
      @(negedge clk_sys);
      chk("ctl", {25'h0, d[9], d[6], d[4], d[2], d[1], d[0], 1'h0}, {25'h0, ctl});
      @(posedge clk_sys);
    end
    for (int i = 0; i < 64; i++)
    begin
      pat = i[3:0];
      per = i[4];
      ser = i[5];
      m = $random(seed);
      flag = pat[3] & pat[2] & per;
      serr = (pat[1] | pat[0]) & ser & per;
      d = {23'h0, ser, 1'h0, per, 6'h0};
      acc(1'h1, 1'h0, PCS_OFF_IMASK, {30'h0, m});
      acc(1'h1, 1'h0, PCS_OFF_CMD, d);
      idle();
      i_eng.fire(pat);
      @(negedge clk_sys);
      chk("serr_assert", {31'h0, serr}, {31'h0, serr_assert});
      chk("irq", {31'h0, |({serr, flag} & m)}, {31'h0, irq});
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("serr_assert", 32'h0, {31'h0, serr_assert});
      @(posedge clk_sys);
      rd(PCS_OFF_CMD, FIXED | d | {7'h0, flag, 24'h0});
      rd(PCS_OFF_ISTAT, {30'h0, serr, flag});
      acc(1'h1, 1'h0, PCS_OFF_CMD, d | 32'h01000000);
      acc(1'h1, 1'h0, PCS_OFF_ISTAT, 32'h3);
      rd(PCS_OFF_CMD, FIXED | d);
      rd(PCS_OFF_ISTAT, 32'h0);
      idle();
      @(negedge clk_sys);
      chk("irq", 32'h0, {31'h0, irq});
      @(posedge clk_sys);
    end
    // mid-run resets walk every strap combination through the bus master default
    for (int k = 0; k < 4; k++)
    begin
      resetn <= 1'h0;
      boot_strap <= k[1];
      host_strap <= k[0];
      repeat (3) @(posedge clk_sys);
      resetn <= 1'h1;
      repeat (4) @(posedge clk_sys);
      rd(PCS_OFF_CMD, FIXED | {29'h0, k[1] & k[0], 2'h0});
      rd(PCS_OFF_IMASK, 32'h0);
      idle();
      @(negedge clk_sys);
      chk("bus_master_enable", {31'h0, k[1] & k[0]}, {31'h0, ctl.bus_master_enable});
      @(posedge clk_sys);
    end
    repeat (2) @(posedge clk_sys);
    stop_test();
  end
endmodule // tb_pci_command_status_low

`default_nettype wire
